// >>> ppe_ctrl.sv
// protected serial memory controller: decode, protection, status and output drive
module ppe_ctrl
  import ppe_pkg::*;
#(
  parameter int unsigned BIT_CYCLES  = BIT_CYC,
  parameter int unsigned PROG_CYCLES = PROG_CYC
) (
  input  wire logic clk_sys_in,
  input  wire logic srst_in,
  input  wire logic ce_in,
  input  wire logic chip_sel_in,
  input  wire logic serial_in,
  input  wire logic parity_select_pin_in,
  output logic      data_out,
  output logic      data_oe_out,
  output logic      err_n_out,
  output logic      err_n_oe_out,
  output logic      busy_out
);
  ppe_ser_if ser ();
  ppe_state_t  st_q;
  ppe_prog_t   pg_q;
  logic [7:0]  mem_q [DEPTH];
  logic [7:0]  code_q [CODE_MAX];
  logic [7:0]  newc_q [CODE_MAX];
  logic [3:0]  clen_q;
  logic [3:0]  nlen_q;
  logic [3:0]  idx_q;
  logic        cmatch_q;
  logic        nmatch_q;
  logic [ADDR_W-1:0] bnd_q;
  logic [ADDR_W-1:0] adr_q;
  logic [7:0]  op_q;
  logic [1:0]  acnt_q;
  logic [7:0]  wdat_q;
  logic        pen_q;
  logic        acc_q;
  logic        bsy_en_q;
  logic        byp_q;
  logic        clrall_q;
  logic        perr_q;
  logic        ierr_q;
  logic [31:0] pcnt_q;
  logic [ADDR_W-1:0] pa_q;
  logic [7:0]  pd_q;
  logic        bsy_hold_q;
  logic        tx_start_q;
  logic [7:0]  tx_data_q;
  logic        tx_line;
  logic        tx_oe;
  logic        run;
  logic        prog;
  logic        secure;
  assign run    = chip_sel_in;
  assign prog   = (pg_q != PG_IDLE);
  assign secure = (clen_q != 4'h0);
  ppe_uart #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
    .clk_sys_in  (clk_sys_in),
    .srst_in     (srst_in),
    .ce_in       (ce_in),
    .run_in      (run && st_q != ST_ERR),
    .parity_in   (parity_select_pin_in),
    .serial_in   (serial_in),
    .tx_line_out (tx_line),
    .tx_oe_out   (tx_oe),
    .ser         (ser)
  );
  assign ser.tx_start = tx_start_q;
  assign ser.tx_data  = tx_data_q;
  // bytes needed after opcode for address
  function automatic logic needs_addr(input logic [7:0] op);
    needs_addr = (op == OP_READ) || (op == OP_STREAM) || (op == OP_WRITE) ||
                 (op == OP_ERASE) || (op == OP_LDBND);
  endfunction
  // program permission for one location
  function automatic logic may_prog(input logic [ADDR_W-1:0] a, input logic byp,
                                    input logic acc, input logic sec,
                                    input logic [ADDR_W-1:0] b);
    if (a >= b) begin
      may_prog = !sec;
    end else begin
      may_prog = byp && (!sec || acc);
    end
  endfunction
  function automatic logic may_read(input logic [ADDR_W-1:0] a, input logic acc,
                                    input logic sec, input logic [ADDR_W-1:0] b);
    may_read = !sec || (a >= b) || acc;
  endfunction
  // instruction sequencer; errors and per-transfer state clear on chip select low
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !run) begin
      st_q       <= ST_OP;
      op_q       <= 8'h00;
      acnt_q     <= 2'h0;
      idx_q      <= 4'h0;
      nlen_q     <= 4'h0;
      cmatch_q   <= 1'b1;
      nmatch_q   <= 1'b1;
      adr_q      <= '0;
      wdat_q     <= 8'h00;
      perr_q     <= 1'b0;
      ierr_q     <= 1'b0;
      tx_start_q <= 1'b0;
      tx_data_q  <= 8'h00;
      bsy_hold_q <= 1'b0;
    end else if (ce_in) begin
      tx_start_q <= 1'b0;
      // ready level must outlive the cycle until the next opcode
      if (prog) bsy_hold_q <= 1'b1;
      if (ser.rx_valid && ser.rx_perr) begin
        perr_q <= 1'b1;
        st_q   <= ST_ERR;
      end else begin
        case (st_q)
          ST_OP: if (ser.rx_valid) begin
            op_q       <= ser.rx_data;
            acnt_q     <= 2'h0;
            bsy_hold_q <= 1'b0;
            if (needs_addr(ser.rx_data)) begin
              st_q <= ST_ADDR;
            end else if (ser.rx_data[7:4] == OP_CHPW_HI) begin
              nlen_q <= ser.rx_data[3:0];
              idx_q  <= 4'h0;
              cmatch_q <= 1'b1;
              nmatch_q <= 1'b1;
              st_q   <= (ser.rx_data[3:0] > 4'(CODE_MAX)) ? ST_DONE
                      : secure ? ST_OLD
                      : (ser.rx_data[3:0] == 4'h0) ? ST_OP : ST_NEW1;
            end else if (ser.rx_data == OP_UNLOCK) begin
              idx_q <= 4'h0;
              cmatch_q <= 1'b1;
              st_q  <= secure ? ST_OLD : ST_OP;
            end else if (ser.rx_data == OP_FILL) begin
              st_q <= clrall_q ? ST_DATA : ST_OP;
            end else if (ser.rx_data == OP_RDSTAT) begin
              tx_data_q  <= {STAT_MARK, perr_q, ierr_q, prog, 2'b00};
              tx_start_q <= 1'b1;
              st_q       <= ST_SEND;
            end else if (ser.rx_data == OP_RDBND) begin
              tx_data_q  <= bnd_q[7:0];
              tx_start_q <= 1'b1;
              st_q       <= ST_SEND;
            end else if (ser.rx_data == OP_LOCK || ser.rx_data == OP_BYPASS ||
                         ser.rx_data == OP_CLRALL || ser.rx_data == OP_BSYOFF ||
                         ser.rx_data == OP_BSYON || ser.rx_data == OP_PUNLOCK ||
                         ser.rx_data == OP_PLOCK || ser.rx_data == OP_NOP ||
                         ser.rx_data[7:1] == OP_WSEL_HI) begin
              st_q <= ST_OP;
            end else begin
              ierr_q <= 1'b1;
              st_q   <= ST_ERR;
            end
          end
          ST_ADDR: if (ser.rx_valid) begin
            acnt_q <= acnt_q + 2'h1;
            adr_q  <= {adr_q[ADDR_W-9:0], ser.rx_data};
            if (acnt_q == 2'h1) begin
              if (op_q == OP_WRITE) begin
                st_q <= ST_DATA;
              end else if (op_q == OP_READ || op_q == OP_STREAM) begin
                tx_data_q  <= may_read({adr_q[0], ser.rx_data}, acc_q, secure, bnd_q)
                              ? mem_q[{adr_q[0], ser.rx_data}] : ERASED;
                tx_start_q <= 1'b1;
                st_q       <= ST_SEND;
              end else begin
                st_q <= ST_OP;
              end
            end
          end
          ST_OLD: if (ser.rx_valid) begin
            cmatch_q <= cmatch_q && (ser.rx_data == code_q[3'(idx_q)]);
            if (idx_q + 4'h1 == clen_q) begin
              idx_q <= 4'h0;
              st_q  <= (op_q == OP_UNLOCK) ? ST_OP : (nlen_q == 4'h0 ? ST_OP : ST_NEW1);
            end else begin
              idx_q <= idx_q + 4'h1;
            end
          end
          ST_NEW1: if (ser.rx_valid) begin
            idx_q <= (idx_q + 4'h1 == nlen_q) ? 4'h0 : idx_q + 4'h1;
            if (idx_q + 4'h1 == nlen_q) begin
              st_q <= ST_NEW2;
            end
          end
          ST_NEW2: if (ser.rx_valid) begin
            nmatch_q <= nmatch_q && (ser.rx_data == newc_q[3'(idx_q)]);
            idx_q    <= idx_q + 4'h1;
            if (idx_q + 4'h1 == nlen_q) begin
              st_q <= ST_OP;
            end
          end
          ST_DATA: if (ser.rx_valid) begin
            wdat_q <= ser.rx_data;
            st_q   <= ST_OP;
          end
          ST_SEND: if (ser.tx_done) begin
            if (op_q == OP_STREAM && adr_q != ADDR_W'(DEPTH - 1)) begin
              adr_q      <= adr_q + 1'b1;
              tx_data_q  <= may_read(adr_q + 1'b1, acc_q, secure, bnd_q)
                            ? mem_q[adr_q + 1'b1] : ERASED;
              tx_start_q <= 1'b1;
            end else begin
              st_q <= ST_OP;
            end
          end
          ST_DONE: st_q <= ST_DONE; // oversize length: ignore rest of transfer
          default: st_q <= ST_ERR;
        endcase
      end
    end
  end
  // completion events of the sequencer, seen one cycle later
  logic ev_ok_q;
  ppe_state_t st_prev_q;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      st_prev_q <= ST_OP;
    end else if (ce_in) begin
      st_prev_q <= st_q;
    end
  end
  assign ev_ok_q = run && (st_q == ST_OP) && (st_prev_q != ST_OP) && (st_prev_q != ST_SEND);
  // persistent enables: not touched by chip select
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pen_q    <= 1'b0;
      acc_q    <= 1'b0;
      bsy_en_q <= 1'b0;
      byp_q    <= 1'b0;
      clrall_q <= 1'b0;
      clen_q   <= CODE_LEN_RST;
      bnd_q    <= BOUND_RST;
    end else if (ce_in && run) begin
      if (ser.rx_valid && st_q == ST_OP && !ser.rx_perr) begin
        if (ser.rx_data == OP_PUNLOCK) pen_q <= 1'b1;
        if (ser.rx_data == OP_PLOCK) pen_q <= 1'b0;
        if (ser.rx_data == OP_LOCK) acc_q <= 1'b0;
        if (ser.rx_data == OP_BSYON) bsy_en_q <= 1'b1;
        if (ser.rx_data == OP_BSYOFF) bsy_en_q <= 1'b0;
        if (ser.rx_data == OP_BYPASS && (!secure || acc_q)) byp_q <= 1'b1;
        clrall_q <= (ser.rx_data == OP_CLRALL) && !clrall_q;
      end
      if (ev_ok_q) begin
        if (op_q == OP_UNLOCK && cmatch_q) acc_q <= 1'b1;
        if (op_q == OP_LDBND && (!secure || acc_q)) bnd_q <= adr_q;
        if (op_q[7:4] == OP_CHPW_HI && cmatch_q && nmatch_q && nlen_q <= 4'(CODE_MAX)) begin
          clen_q <= nlen_q;
          if (nlen_q == 4'h0) acc_q <= 1'b0;
        end
        if (op_q == OP_WRITE || op_q == OP_ERASE || op_q == OP_FILL) byp_q <= 1'b0;
      end
    end
  end
  // code capture and array programming
  always_ff @(posedge clk_sys_in) begin
    if (ce_in && run && ser.rx_valid && st_q == ST_NEW1) begin
      newc_q[3'(idx_q)] <= ser.rx_data;
    end
    if (ce_in && run && ev_ok_q && op_q[7:4] == OP_CHPW_HI && cmatch_q && nmatch_q) begin
      for (int i = 0; i < CODE_MAX; i++) code_q[i] <= newc_q[i];
    end
    if (ce_in && pg_q != PG_IDLE && pcnt_q == 32'h0000_0000) begin
      if (pg_q == PG_ALL) begin
        for (int i = 0; i < DEPTH; i++) mem_q[i] <= pd_q;
      end else begin
        mem_q[pa_q] <= pd_q;
      end
    end
  end
  // self-timed program cycle; survives chip select low
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      pg_q   <= PG_IDLE;
      pcnt_q <= 32'h0000_0000;
      pa_q   <= '0;
      pd_q   <= ERASED;
    end else if (ce_in) begin
      if (pg_q != PG_IDLE) begin
        if (pcnt_q == 32'h0000_0000) pg_q <= PG_IDLE;
        else pcnt_q <= pcnt_q - 32'h0000_0001;
      end else if (run && pen_q && ser.rx_valid && !ser.rx_perr && st_q == ST_OP &&
                   ser.rx_data == OP_CLRALL) begin
        // clear-all has no operand bytes, so it starts on its opcode
        pg_q   <= PG_ALL;
        pcnt_q <= 32'(PROG_CYCLES - 1);
        pd_q   <= ERASED;
      end else if (run && ev_ok_q && pen_q) begin
        // target and data latched: chip select low wipes the sequencer copies
        if (op_q == OP_FILL) begin
          pg_q   <= PG_ALL;
          pcnt_q <= 32'(PROG_CYCLES - 1);
          pd_q   <= wdat_q;
        end else if ((op_q == OP_WRITE || op_q == OP_ERASE) &&
                     may_prog(adr_q, byp_q, acc_q, secure, bnd_q)) begin
          pg_q   <= PG_ONE;
          pcnt_q <= 32'(PROG_CYCLES - 1);
          pa_q   <= adr_q;
          pd_q   <= (op_q == OP_ERASE) ? ERASED : wdat_q;
        end
      end
    end
  end
  // output pin: serial data, else busy/ready level, else released
  always_comb begin
    data_out    = 1'b1;
    data_oe_out = 1'b0;
    if (run && st_q != ST_ERR) begin
      if (tx_oe) begin
        data_out    = tx_line;
        data_oe_out = 1'b1;
      end else if (bsy_en_q && (prog || bsy_hold_q)) begin
        data_out    = !prog;
        data_oe_out = 1'b1;
      end
    end
  end
  assign err_n_out    = 1'b0;
  assign err_n_oe_out = perr_q || ierr_q;
  assign busy_out     = prog;
endmodule : ppe_ctrl

// >>> ppe_ctrl_sva.sv
// port checker for the protected serial memory controller
module ppe_ctrl_chk #(
  parameter int unsigned PROG_CYCLES = 50
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic chip_sel_in,
  input wire logic serial_in,
  input wire logic parity_select_pin_in,
  input wire logic data_out,
  input wire logic data_oe_out,
  input wire logic err_n_out,
  input wire logic err_n_oe_out,
  input wire logic busy_out
);
  logic [15:0] run_q;
  // length of the current program cycle, cleared whenever it is idle
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !busy_out) begin
      run_q <= 16'h0000;
    end else begin
      run_q <= run_q + 16'h0001;
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  sequence s_cs_low2;
    !chip_sel_in ##1 !chip_sel_in;
  endsequence
  sequence s_err_held;
    err_n_oe_out && chip_sel_in ##1 chip_sel_in;
  endsequence
  a_cs_release: assert property (s_cs_low2 |-> !data_oe_out)
    else $error("output driven while chip select low");
  a_err_level: assert property (err_n_oe_out |-> !err_n_out)
    else $error("error pin not pulled low");
  a_err_hold: assert property (s_err_held |-> err_n_oe_out)
    else $error("error pin released without chip select reset");
  a_err_clear: assert property (!chip_sel_in [*3] |-> !err_n_oe_out)
    else $error("error pin still active after chip select reset");
  a_err_quiet: assert property (err_n_oe_out && $past(err_n_oe_out) |-> !data_oe_out)
    else $error("output driven in error state");
  a_err_rise: assert property ($rose(err_n_oe_out) |-> $past(chip_sel_in))
    else $error("error raised while deselected");
  a_drive_low: assert property ($rose(data_oe_out) |-> !data_out)
    else $error("output drive starts high");
  a_busy_len: assert property ($fell(busy_out) |->
    (run_q >= PROG_CYCLES - 1) && (run_q <= PROG_CYCLES + 2))
    else $error("program cycle length wrong");
endmodule // ppe_ctrl_chk
bind ppe_ctrl ppe_ctrl_chk #(.PROG_CYCLES(PROG_CYCLES)) u_ppe_ctrl_chk (
  .clk_sys_in, .srst_in, .ce_in, .chip_sel_in, .serial_in, .parity_select_pin_in,
  .data_out, .data_oe_out, .err_n_out, .err_n_oe_out, .busy_out);

// >>> ppe_host_model.sv
// host side model: frames bytes onto the serial input and reads answers
module ppe_host_model #(
  parameter int unsigned BIT_CYCLES = 16
) (
  input  wire logic clk_in,
  input  wire logic par_in,
  input  wire logic data_in,
  input  wire logic data_oe_in,
  output logic      serial_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q = 1'b1;
  logic line;
  always_ff @(posedge clk_in) begin
    if (data_oe_in) begin
      last_q <= data_in;
    end
  end
  // released line shows the inverse, so stale data cannot pass
  assign line = data_oe_in ? data_in : ~last_q;
  initial serial_out = 1'b1;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic bits(input logic v, input int n);
    serial_out = v;
    tick(n);
  endtask
  task automatic send(input logic [7:0] b, input logic bad);
    bits(1'b1, BIT_CYCLES / 2);
    bits(1'b0, BIT_CYCLES);
    for (int i = 0; i < 8; i++) bits(b[i], BIT_CYCLES);
    if (par_in) bits(^b ^ bad, BIT_CYCLES);
    bits(1'b1, BIT_CYCLES / 2);
  endtask
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    ok = 1'b0;
    while (!(data_oe_in && !data_in) && n < 40 * BIT_CYCLES) begin
      tick(1);
      n++;
    end
    if (n >= 40 * BIT_CYCLES) return;
    tick(BIT_CYCLES / 2);
    for (int i = 0; i < 8; i++) begin
      tick(BIT_CYCLES);
      b[i] = line;
    end
    ok = 1'b1;
    if (par_in) begin
      tick(BIT_CYCLES);
      ok = (line === ^b);
    end
    tick(BIT_CYCLES / 2);
  endtask
endmodule // ppe_host_model

// >>> ppe_pkg.sv
// constants and types shared by the protected serial memory controller
// Notes on behaviour
// - chip select low resets instruction logic, aborts transfers, output released.
// - chip select reset keeps program enable, access enable and running cycle.
// - bit timing comes from system clock through an internal divider.
// - each received byte starts with a zero start bit.
// - take exactly the bytes needed; idle ones ignored; zero starts next.
// - unknown instruction aborts and locks serial io until chip select reset.
// - output released except while data or busy is driven, and after each stream.
// - busy enabled: output low during cycle, high after, until next opcode.
// - busy disabled or error: output stays released.
// - status read works while busy; no answer in error.
// - parity select high frames bytes with even parity; low means none.
// - open-drain error output low on any error until chip select reset.
// - decoder supports nineteen instructions in three groups.
// - every write replaces the target cell when its program cycle ends.
// - initial state: code length zero, boundary zero, full access.
// - unprotected: program and erase blocked below boundary.
// - whole-array clear and fill ignore boundary protection.
// - secure: at or above boundary read only; below needs unlock with code.
// - code change needs old code and two agreeing copies of new code.
// - code length zero returns to unprotected mode.
// - no program without unlock; below boundary needs one-shot bypass each time.
// - boundary load is retained; secure mode needs unlock for load and bypass.
// - status word is 101, parity error, instruction error, busy, two reserved.
// - with parity each byte carries a ninth parity bit.
// - busy status read returns 101 00100.
package ppe_pkg;
  localparam int unsigned CLK_HZ       = 125000000;
  localparam int unsigned BAUD         = 9600;
  localparam int unsigned BIT_CYC      = CLK_HZ / BAUD;
  localparam int unsigned PROG_MS      = 12;
  localparam int unsigned PROG_CYC     = (CLK_HZ / 1000) * PROG_MS;
  localparam int unsigned ADDR_W       = 9;
  localparam int unsigned DEPTH        = 512;
  localparam int unsigned CODE_MAX     = 8;
  localparam logic [ADDR_W-1:0] BOUND_RST = 9'h000;
  localparam logic [3:0]  CODE_LEN_RST = 4'h0;
  localparam logic [2:0]  STAT_MARK    = 3'h5;
  localparam logic [7:0]  ERASED       = 8'hFF;
  localparam logic [7:0]  OP_LOCK      = 8'h88;
  localparam logic [7:0]  OP_UNLOCK    = 8'hC5;
  localparam logic [3:0]  OP_CHPW_HI   = 4'hD;
  localparam logic [7:0]  OP_BYPASS    = 8'h83;
  localparam logic [7:0]  OP_RDBND     = 8'hCA;
  localparam logic [7:0]  OP_LDBND     = 8'hC4;
  localparam logic [7:0]  OP_CLRALL    = 8'h89;
  localparam logic [7:0]  OP_ERASE     = 8'hC0;
  localparam logic [7:0]  OP_READ      = 8'hC9;
  localparam logic [7:0]  OP_STREAM    = 8'hCB;
  localparam logic [7:0]  OP_FILL      = 8'hC3;
  localparam logic [7:0]  OP_WRITE     = 8'hC1;
  localparam logic [7:0]  OP_BSYOFF    = 8'h85;
  localparam logic [7:0]  OP_BSYON     = 8'h84;
  localparam logic [7:0]  OP_PUNLOCK   = 8'h81;
  localparam logic [7:0]  OP_PLOCK     = 8'h82;
  localparam logic [6:0]  OP_WSEL_HI   = 7'h43;
  localparam logic [7:0]  OP_NOP       = 8'h80;
  localparam logic [7:0]  OP_RDSTAT    = 8'h8A;
  typedef enum {ST_OP, ST_ADDR, ST_LEN, ST_OLD, ST_NEW1, ST_NEW2, ST_DATA, ST_SEND,
                ST_DONE, ST_ERR} ppe_state_t;
  typedef enum {PG_IDLE, PG_ONE, PG_ALL} ppe_prog_t;
endpackage : ppe_pkg

// >>> ppe_ser_if.sv
// byte-level carrier between controller and serial framer
interface ppe_ser_if;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       rx_perr;
  logic       tx_start;
  logic [7:0] tx_data;
  logic       tx_busy;
  logic       tx_done;
  modport ctl (input rx_valid, rx_data, rx_perr, tx_busy, tx_done, output tx_start, tx_data);
  modport phy (output rx_valid, rx_data, rx_perr, tx_busy, tx_done, input tx_start, tx_data);
endinterface : ppe_ser_if

// >>> ppe_uart.sv
// asynchronous serial receiver and transmitter with optional even parity
module ppe_uart
  import ppe_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = BIT_CYC
) (
  input  wire logic clk_sys_in,
  input  wire logic srst_in,
  input  wire logic ce_in,
  input  wire logic run_in,
  input  wire logic parity_in,
  input  wire logic serial_in,
  output logic      tx_line_out,
  output logic      tx_oe_out,
  ppe_ser_if.phy    ser
);
  localparam logic [15:0] BITC = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYCLES / 2);
  logic [15:0] rdiv_q;
  logic [3:0]  rbit_q;
  logic        ract_q;
  logic [8:0]  rsh_q;
  logic [15:0] tdiv_q;
  logic [3:0]  tbit_q;
  logic [10:0] tsh_q;
  logic        tact_q;
  logic [3:0]  rlast;
  assign rlast = parity_in ? 4'h9 : 4'h8;
  // receiver samples mid-bit from the internal divider
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !run_in) begin
      ract_q         <= 1'b0;
      rdiv_q         <= 16'h0000;
      rbit_q         <= 4'h0;
      rsh_q          <= 9'h000;
      ser.rx_valid   <= 1'b0;
      ser.rx_data    <= 8'h00;
      ser.rx_perr    <= 1'b0;
    end else if (ce_in) begin
      ser.rx_valid <= 1'b0;
      if (!ract_q) begin
        if (!serial_in) begin
          ract_q <= 1'b1;
          rdiv_q <= HALF;
          rbit_q <= 4'h0;
        end
      end else if (rdiv_q != 16'h0000) begin
        rdiv_q <= rdiv_q - 16'h0001;
      end else begin
        rdiv_q <= BITC;
        rbit_q <= rbit_q + 4'h1;
        if (rbit_q == 4'h0 && serial_in) begin
          ract_q <= 1'b0; // glitch, not a start bit
        end else if (rbit_q != 4'h0 && rbit_q <= rlast) begin
          rsh_q <= {serial_in, rsh_q[8:1]};
        end else if (rbit_q > rlast) begin
          ract_q       <= 1'b0;
          ser.rx_valid <= 1'b1;
          ser.rx_data  <= parity_in ? rsh_q[7:0] : rsh_q[8:1];
          ser.rx_perr  <= parity_in && (^rsh_q);
        end
      end
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !run_in) begin
      tact_q      <= 1'b0;
      tdiv_q      <= 16'h0000;
      tbit_q      <= 4'h0;
      tsh_q       <= 11'h7FF;
      ser.tx_done <= 1'b0;
    end else if (ce_in) begin
      ser.tx_done <= 1'b0;
      if (!tact_q) begin
        if (ser.tx_start) begin
          tact_q <= 1'b1;
          tdiv_q <= BITC;
          tbit_q <= 4'h0;
          tsh_q  <= parity_in ? {1'b1, ^ser.tx_data, ser.tx_data, 1'b0}
                              : {2'b11, ser.tx_data, 1'b0};
        end
      end else if (tdiv_q != 16'h0000) begin
        tdiv_q <= tdiv_q - 16'h0001;
      end else begin
        tdiv_q <= BITC;
        tsh_q  <= {1'b1, tsh_q[10:1]};
        tbit_q <= tbit_q + 4'h1;
        if (tbit_q == rlast + 4'h1) begin
          tact_q      <= 1'b0;
          ser.tx_done <= 1'b1;
        end
      end
    end
  end
  assign ser.tx_busy = tact_q;
  assign tx_line_out = tsh_q[0];
  assign tx_oe_out   = tact_q;
endmodule : ppe_uart

// >>> testbench.sv
// self-checking bench for the protected serial memory controller
module testbench
  import ppe_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned BITC  = 16;
  localparam int unsigned PROGC = 1000;
  logic       clk  = 1'b0;
  logic       srst = 1'b1;
  logic       cs   = 1'b0;
  logic       par  = 1'b0;
  logic       ser, d_out, d_oe, e_n, e_oe, busy, ok;
  logic [7:0] rx;
  int         error_cnt = 0;
  int         cmp_count = 0;
  initial forever #4 clk = ~clk;
  ppe_ctrl #(.BIT_CYCLES(BITC), .PROG_CYCLES(PROGC)) u_ppe_ctrl (
    .clk_sys_in(clk), .srst_in(srst), .ce_in(1'b1), .chip_sel_in(cs),
    .serial_in(ser), .parity_select_pin_in(par), .data_out(d_out),
    .data_oe_out(d_oe), .err_n_out(e_n), .err_n_oe_out(e_oe), .busy_out(busy));
  ppe_host_model #(.BIT_CYCLES(BITC)) u_host (
    .clk_in(clk), .par_in(par), .data_in(d_out), .data_oe_in(d_oe), .serial_out(ser));
  task automatic summarize();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic op(input logic [7:0] b);
    u_host.send(b, 1'b0);
  endtask
  task automatic addr(input logic [8:0] a);
    op({7'h00, a[8]});
    op(a[7:0]);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    op(OP_WRITE);
    addr(a);
    op(d);
  endtask
  // a missing or badly framed answer reads as unknown
  task automatic get(input string nm, input logic [7:0] exp);
    u_host.recv(rx, ok);
    chk(nm, exp, ok ? rx : 8'hXX);
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    op(OP_READ);
    addr(a);
    get("read data", exp);
  endtask
  task automatic waitb();
    int n;
    n = 0;
    tick(4);
    while (busy !== 1'b0 && n < 3 * PROGC) begin
      tick(1);
      n++;
    end
    if (n >= 3 * PROGC) begin
      error_cnt++;
      $display("unexpected busy: expected 0 seen %b", busy);
      summarize();
    end
  endtask
  task automatic cs_pulse();
    cs = 1'b0;
    tick(3);
    cs = 1'b1;
    tick(2);
  endtask
  initial begin
    tick(16);
    srst = 1'b0;
    cs = 1'b1;
    tick(2);
    op(OP_RDSTAT);
    get("status", 8'hA0);
    op(OP_PUNLOCK);
    wr(9'h005, 8'h3C);
    op(OP_RDSTAT);
    get("busy status", 8'hA4);
    cs_pulse();
    chk("busy kept", 8'h01, {7'h00, busy});
    waitb();
    rd(9'h005, 8'h3C);
    op(OP_BSYON);
    wr(9'h006, 8'h5A);
    tick(BITC);
    chk("busy drive", 8'h02, {6'h00, d_oe, d_out});
    waitb();
    chk("ready drive", 8'h03, {6'h00, d_oe, d_out});
    op(OP_NOP);
    tick(4);
    chk("released", 8'h00, {7'h00, d_oe});
    op(OP_BSYOFF);
    op(OP_LDBND);
    addr(9'h010);
    waitb();
    wr(9'h005, 8'h77);
    tick(BITC);
    chk("blocked", 8'h00, {7'h00, busy});
    op(OP_BYPASS);
    wr(9'h005, 8'h77);
    waitb();
    rd(9'h005, 8'h77);
    wr(9'h005, 8'h66);
    tick(BITC);
    chk("bypass lapsed", 8'h00, {7'h00, busy});
    op(OP_CLRALL);
    waitb();
    rd(9'h005, ERASED);
    op(8'h00);
    tick(4);
    chk("error pin", 8'h02, {6'h00, e_oe, e_n});
    op(OP_RDSTAT);
    get("error silence", 8'hXX);
    cs_pulse();
    chk("error cleared", 8'h00, {7'h00, e_oe});
    wr(9'h020, 8'h99);
    waitb();
    rd(9'h020, 8'h99);
    op(OP_PLOCK);
    wr(9'h021, 8'h12);
    tick(BITC);
    chk("locked", 8'h00, {7'h00, busy});
    par = 1'b1;
    op(OP_RDSTAT);
    get("parity status", 8'hA0);
    u_host.send(OP_RDSTAT, 1'b1);
    tick(4);
    chk("parity error", 8'h01, {7'h00, e_oe});
    summarize();
  end
endmodule // testbench
